// ==== pcr_consts.vh ====
// Purpose: constants for the port control mask and output register bank
// Assumes: APB with 32-bit data, one word per register
// Notes: byte address is four times the register index
//
// Summary of operation
// - Power mask holds eight source mask bits; 0 masks, 1 unmasks.
// - Power mask returns to all ones on power-on, software and hard reset.
// - Fault mask has read-write bits 7, 5, 4, 1, 0; 0 masks, 1 unmasks.
// - Fault mask bits 6, 3, 2 read zero; resets to B3 on all resets.
// - Output config bit 7 set forces every side output to high impedance.
// - Bit 6 drives accessory indicator; writes ignored while owner bit is 0.
// - Output config field 3:2 drives the two lane select outputs while the host owns them.
// - Output config bit 0 drives the orientation output, 1 means flipped.
// - Output config resets to 40; bits 5, 4, 1 read as zero.
// - Core control bit 5 enables watchdog monitoring; disabled after reset.
// - Core control bit 4 selects who owns side outputs: 0 device, 1 host.
// - Stretch field bits 3:2 always read 00; writes to it are ignored.
// - Core control bit 1 set flushes receive buffer right after acknowledgement.
// - Core control bit 0 picks cable power and monitoring pin orientation.
// - Core control resets to 00 on power-on and software reset only.
// - Each alert rises when status ANDed with its mask is nonzero.
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// Register indices
`define PCR_IDX_PWR_MASK 8'h14
`define PCR_IDX_FAULT_MASK 8'h15
`define PCR_IDX_OUT_CFG 8'h18
`define PCR_IDX_CORE_CTRL 8'h19
`define PCR_IDX_IRQ_STATUS 8'h20
`define PCR_IDX_IRQ_MASK 8'h21

// Reset values
`define PCR_RST_PWR_MASK 8'hFF
`define PCR_RST_FAULT_MASK 8'hB3
`define PCR_RST_OUT_CFG 8'h40
`define PCR_RST_CORE_CTRL 8'h00
`define PCR_RST_IRQ 3'h0

// Writable bit sets
`define PCR_WR_FAULT_MASK 8'hB3
`define PCR_WR_OUT_CFG 8'hCD
`define PCR_WR_CORE_CTRL 8'h33

// Field positions
`define PCR_OUT_TRI 7
`define PCR_OUT_ACC 6
`define PCR_OUT_LANE_HI 3
`define PCR_OUT_LANE_LO 2
`define PCR_OUT_FLIP 0
`define PCR_CORE_WDOG 5
`define PCR_CORE_OWNER 4
`define PCR_CORE_SELFTEST 1
`define PCR_CORE_FLIP 0

// Interrupt status bits
`define PCR_IRQ_PWR 0
`define PCR_IRQ_FAULT 1
`define PCR_IRQ_HARD 2

`endif

// ==== pcr_alert.v ====
// Purpose: masked status summary with a rise event
// Assumes: status comes from logic on pclk
// Notes: alert is registered, rise is a one-cycle pulse
`timescale 1ns/1ps
module pcr_alert (
  input wire pclk,
  input wire presetn,
  input wire [7:0] status,
  input wire [7:0] mask,
  output reg alert,
  output wire rise
);
  // Any unmasked set status bit raises the alert
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert <= 1'b0;
    end else begin
      alert <= |(status & mask);
    end
  end

  reg alert_d;
  // Delayed copy for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_d <= 1'b0;
    end else begin
      alert_d <= alert;
    end
  end

  assign rise = alert & ~alert_d;
endmodule

// ==== pcr_outpin.v ====
// Purpose: one three-state side output with registered drive
// Assumes: control inputs are on pclk
// Notes: oe low means the pin floats; the drive level parks at rst_level while float_all is set, and at 0 in reset
`timescale 1ns/1ps
module pcr_outpin (
  input wire pclk,
  input wire presetn,
  input wire value,
  input wire float_all,
  input wire rst_level,
  output reg pin_out,
  output reg pin_oe
);
  // Drive level and enable both come from flops to avoid glitches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      // Park the level while floated; on leaving tri-state the pin drives value in the same cycle
      if (float_all) begin
        pin_out <= rst_level;
      end else begin
        pin_out <= value;
      end
      pin_oe <= ~float_all;
    end
  end
endmodule

// ==== pcr_regs.v ====
// Purpose: mask, side output and core control registers over APB
// Assumes: single clock pclk; status, resets and events come from pclk logic
// Notes: zero wait states; unmapped addresses answer with pslverr
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "pcr_consts.vh"
module pcr_regs (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire software_reset,
  input wire hard_reset_rx,
  input wire [7:0] power_status_reg,
  input wire [7:0] fault_status_reg,
  input wire auto_accessory_level,
  input wire [1:0] auto_lane_select,
  input wire auto_plug_flip,
  input wire goodcrc_sent,
  output wire power_alert,
  output wire fault_alert,
  output reg irq,
  output wire accessory_indicator_out,
  output wire accessory_indicator_oe,
  output wire lane_select0_out,
  output wire lane_select0_oe,
  output wire lane_select1_out,
  output wire lane_select1_oe,
  output wire plug_flip_out,
  output wire plug_flip_oe,
  output wire watchdog_enable,
  output wire side_output_owner,
  output wire selftest_receive_mode,
  output wire cable_power_on_cc1,
  output wire monitor_on_cc2,
  output reg rx_flush
);

  // Register storage
  // Only byte lane 0 is implemented; upper read bits are always zero
  reg [7:0] power_status_event_mask;
  reg [7:0] fault_event_mask;
  reg [7:0] side_output_config;
  reg [7:0] port_core_control;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;

  // Decoded address
  wire [9:0] word_idx;
  wire addr_aligned;
  reg hit_pwr;
  reg hit_fault;
  reg hit_out;
  reg hit_core;
  reg hit_ists;
  reg hit_imsk;
  wire hit_any;

  // Bus phase strobes
  wire setup_ph;
  wire wr_acc;
  wire wr_lane0;

  // Event plumbing
  wire pwr_rise;
  wire fault_rise;
  wire [2:0] irq_events;
  reg [2:0] next_irq_status;

  // Side output values
  wire sel_owner;
  reg acc_value;
  reg [1:0] lane_value;
  reg flip_value;
  wire float_all;

  // Byte address to register index
  // Low address bits must be zero; a misaligned access hits nothing and errors
  assign word_idx = paddr[11:2];
  assign addr_aligned = (paddr[1:0] == 2'b00);

  // Address decode on the word index
  always @* begin
    hit_pwr = 1'b0;
    hit_fault = 1'b0;
    hit_out = 1'b0;
    hit_core = 1'b0;
    hit_ists = 1'b0;
    hit_imsk = 1'b0;
    if (!addr_aligned) begin
      hit_pwr = 1'b0;
    end else if (word_idx == {2'b00, `PCR_IDX_PWR_MASK}) begin
      hit_pwr = 1'b1;
    end else if (word_idx == {2'b00, `PCR_IDX_FAULT_MASK}) begin
      hit_fault = 1'b1;
    end else if (word_idx == {2'b00, `PCR_IDX_OUT_CFG}) begin
      hit_out = 1'b1;
    end else if (word_idx == {2'b00, `PCR_IDX_CORE_CTRL}) begin
      hit_core = 1'b1;
    end else if (word_idx == {2'b00, `PCR_IDX_IRQ_STATUS}) begin
      hit_ists = 1'b1;
    end else if (word_idx == {2'b00, `PCR_IDX_IRQ_MASK}) begin
      hit_imsk = 1'b1;
    end
  end

  assign hit_any = hit_pwr | hit_fault | hit_out | hit_core | hit_ists | hit_imsk;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  assign setup_ph = psel & ~penable;
  // Only byte lane 0 carries register data; other lanes are dropped
  assign wr_acc = psel & penable & pwrite & hit_any;
  assign wr_lane0 = wr_acc & pstrb[0];

  // Read data captured in setup so it comes from a flop in access
  // Costs one flop stage but keeps prdata free of decode glitches
  // A status bit set between setup and access shows on the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ph) begin
      prdata <= 32'h00000000;
      if (hit_pwr) begin
        prdata[7:0] <= power_status_event_mask;
      end else if (hit_fault) begin
        prdata[7:0] <= fault_event_mask;
      end else if (hit_out) begin
        prdata[7:0] <= side_output_config;
      end else if (hit_core) begin
        prdata[7:0] <= port_core_control;
      end else if (hit_ists) begin
        prdata[2:0] <= irq_status;
      end else if (hit_imsk) begin
        prdata[2:0] <= irq_mask;
      end
    end
  end

  // Power mask: plain read-write byte, all ones on every reset kind
  // Software and received hard resets are synchronous pulses from pclk logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_status_event_mask <= `PCR_RST_PWR_MASK;
    end else if (software_reset || hard_reset_rx) begin
      power_status_event_mask <= `PCR_RST_PWR_MASK;
    end else if (wr_lane0 && hit_pwr) begin
      power_status_event_mask <= pwdata[7:0];
    end
  end

  // Fault mask: read-only bits stay zero whatever is written
  // The writable-bit mask keeps bits 6, 3 and 2 at zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_event_mask <= `PCR_RST_FAULT_MASK;
    end else if (software_reset || hard_reset_rx) begin
      fault_event_mask <= `PCR_RST_FAULT_MASK;
    end else if (wr_lane0 && hit_fault) begin
      fault_event_mask <= pwdata[7:0] & `PCR_WR_FAULT_MASK;
    end
  end

  // Side output config; the accessory bit is locked while device owns outputs.
  // Hard reset is not listed for this register, so it is left alone then.
  // Reserved bits are rewritten to zero on every write, never to one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      side_output_config <= `PCR_RST_OUT_CFG;
    end else if (software_reset) begin
      side_output_config <= `PCR_RST_OUT_CFG;
    end else if (wr_lane0 && hit_out) begin
      side_output_config[`PCR_OUT_TRI] <= pwdata[`PCR_OUT_TRI];
      if (port_core_control[`PCR_CORE_OWNER]) begin
        side_output_config[`PCR_OUT_ACC] <= pwdata[`PCR_OUT_ACC];
      end
      side_output_config[`PCR_OUT_LANE_HI:`PCR_OUT_LANE_LO] <=
        pwdata[`PCR_OUT_LANE_HI:`PCR_OUT_LANE_LO];
      side_output_config[`PCR_OUT_FLIP] <= pwdata[`PCR_OUT_FLIP];
      side_output_config[5:4] <= 2'b00;
      side_output_config[1] <= 1'b0;
    end
  end

  // Core control survives a received hard reset
  // Stretch field and bits 7:6 are masked off on write, so they always read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_core_control <= `PCR_RST_CORE_CTRL;
    end else if (software_reset) begin
      port_core_control <= `PCR_RST_CORE_CTRL;
    end else if (wr_lane0 && hit_core) begin
      port_core_control <= pwdata[7:0] & `PCR_WR_CORE_CTRL;
    end
  end

  // Core control fields out to the rest of the controller
  // One bit steers both cable power and monitoring, so the two never disagree
  assign watchdog_enable = port_core_control[`PCR_CORE_WDOG];
  assign side_output_owner = port_core_control[`PCR_CORE_OWNER];
  assign selftest_receive_mode = port_core_control[`PCR_CORE_SELFTEST];
  assign cable_power_on_cc1 = port_core_control[`PCR_CORE_FLIP];
  assign monitor_on_cc2 = port_core_control[`PCR_CORE_FLIP];

  // Self-test: drop the received message once it has been acknowledged
  // The flush comes one cycle after the acknowledgement; buffer logic acts on it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flush <= 1'b0;
    end else begin
      rx_flush <= goodcrc_sent & port_core_control[`PCR_CORE_SELFTEST];
    end
  end

  // Masked status summaries
  pcr_alert u_pwr_alert (
    .pclk(pclk),
    .presetn(presetn),
    .status(power_status_reg),
    .mask(power_status_event_mask),
    .alert(power_alert),
    .rise(pwr_rise)
  );

  pcr_alert u_fault_alert (
    .pclk(pclk),
    .presetn(presetn),
    .status(fault_status_reg),
    .mask(fault_event_mask),
    .alert(fault_alert),
    .rise(fault_rise)
  );

  // Interrupt events: alert rises and a received hard reset
  // An alert level that stays high sets its status bit only once
  assign irq_events = {hard_reset_rx, fault_rise, pwr_rise};

  // Sticky status, write one to clear; a new event beats the clear
  // Clear first, then OR in events, so an event in the clear cycle survives
  always @* begin
    next_irq_status = irq_status;
    if (wr_lane0 && hit_ists) begin
      next_irq_status = irq_status & ~pwdata[2:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `PCR_RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Interrupt enable mask
  // Not cleared by a received hard reset, so software keeps its choice
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `PCR_RST_IRQ;
    end else if (software_reset) begin
      irq_mask <= `PCR_RST_IRQ;
    end else if (wr_lane0 && hit_imsk) begin
      irq_mask <= pwdata[2:0];
    end
  end

  // Level interrupt, registered for a clean output
  // Uses the next status so irq rises in the cycle the status bit sets
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // Pick output values by owner: device logic or the config register
  // Config bits other than the accessory bit are still stored while the device owns the outputs
  assign sel_owner = port_core_control[`PCR_CORE_OWNER];
  assign float_all = side_output_config[`PCR_OUT_TRI];

  always @* begin
    if (sel_owner) begin
      acc_value = side_output_config[`PCR_OUT_ACC];
      lane_value = side_output_config[`PCR_OUT_LANE_HI:`PCR_OUT_LANE_LO];
      flip_value = side_output_config[`PCR_OUT_FLIP];
    end else begin
      acc_value = auto_accessory_level;
      lane_value = auto_lane_select;
      flip_value = auto_plug_flip;
    end
  end

  // Accessory indicator is low when an accessory is attached
  // It parks high, the no-accessory level, while config bit 7 floats the outputs; reset holds it low
  pcr_outpin u_acc_pin (
    .pclk(pclk),
    .presetn(presetn),
    .value(acc_value),
    .float_all(float_all),
    .rst_level(1'b1),
    .pin_out(accessory_indicator_out),
    .pin_oe(accessory_indicator_oe)
  );

  // Lane select 0 follows field bit 2
  pcr_outpin u_lane0_pin (
    .pclk(pclk),
    .presetn(presetn),
    .value(lane_value[0]),
    .float_all(float_all),
    .rst_level(1'b0),
    .pin_out(lane_select0_out),
    .pin_oe(lane_select0_oe)
  );

  // Lane select 1 follows field bit 3
  pcr_outpin u_lane1_pin (
    .pclk(pclk),
    .presetn(presetn),
    .value(lane_value[1]),
    .float_all(float_all),
    .rst_level(1'b0),
    .pin_out(lane_select1_out),
    .pin_oe(lane_select1_oe)
  );

  // Orientation output, high when flipped
  pcr_outpin u_flip_pin (
    .pclk(pclk),
    .presetn(presetn),
    .value(flip_value),
    .float_all(float_all),
    .rst_level(1'b0),
    .pin_out(plug_flip_out),
    .pin_oe(plug_flip_oe)
  );

endmodule

// ==== pcr_regs_monitor.sv ====
// Purpose: port-level checks on the mask and side output register bank
// Assumes: one clock pclk, presetn asynchronous and active low
// Notes: masks are internal, so alerts are only tied to an all-zero status
`timescale 1ns/1ps
module pcr_regs_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire software_reset,
  input wire hard_reset_rx,
  input wire [7:0] power_status_reg,
  input wire [7:0] fault_status_reg,
  input wire auto_plug_flip,
  input wire goodcrc_sent,
  input wire power_alert,
  input wire fault_alert,
  input wire plug_flip_out,
  input wire plug_flip_oe,
  input wire accessory_indicator_oe,
  input wire lane_select0_oe,
  input wire lane_select1_oe,
  input wire watchdog_enable,
  input wire side_output_owner,
  input wire selftest_receive_mode,
  input wire cable_power_on_cc1,
  input wire monitor_on_cc2,
  input wire rx_flush
);
  // All checks share the one clock and its reset
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_pwr_quiet:
  assert property (power_status_reg == 8'h00 |=> !power_alert)
    else $error("power alert raised with empty status");
  chk_fault_quiet:
  assert property (fault_status_reg == 8'h00 |=> !fault_alert)
    else $error("fault alert raised with empty status");
  chk_flush_hit:
  assert property (goodcrc_sent && selftest_receive_mode |=> rx_flush)
    else $error("receive flush missing in self-test mode");
  chk_flush_idle:
  assert property (!(goodcrc_sent && selftest_receive_mode) |=> !rx_flush)
    else $error("receive flush without cause");
  chk_tri_all:
  assert property (!accessory_indicator_oe |-> !lane_select0_oe && !lane_select1_oe
    && !plug_flip_oe)
    else $error("side outputs not floated together");
  chk_flip_pair:
  assert property (psel && penable && pwrite && pstrb[0] && paddr == 12'h064
    && !software_reset
    |=> cable_power_on_cc1 == $past(pwdata[0]) && monitor_on_cc2 == $past(pwdata[0]))
    else $error("orientation outputs do not follow core control");
  // A received hard reset must not touch core control
  chk_hard_keep:
  assert property (hard_reset_rx && !software_reset && !(psel && pwrite) |=>
    $stable(watchdog_enable) && $stable(side_output_owner) && $stable(selftest_receive_mode))
    else $error("core control changed by hard reset");
  chk_sw_clear:
  assert property (software_reset && !(psel && pwrite) |=> !watchdog_enable
    && !side_output_owner)
    else $error("core control kept through software reset");
  // Three quiet cycles cover the pin register latency
  chk_owner_auto:
  assert property ((!side_output_owner && $stable(auto_plug_flip))[*3] ##0 plug_flip_oe
    |-> plug_flip_out == auto_plug_flip)
    else $error("device-owned flip output ignores its source");
  chk_rd_upper:
  assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_err_phase:
  assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
endmodule
bind pcr_regs pcr_regs_monitor mon (.*);

// ==== pcr_regs_tb.sv ====
// Purpose: directed test of the mask and side output register bank
// Assumes: APB master with one idle cycle between transfers
// Notes: byte addresses are four times the register index
`timescale 1ns/1ps
module pcr_regs_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic software_reset = 0, hard_reset_rx = 0, goodcrc_sent = 0;
  logic [7:0] power_status_reg = 8'h00, fault_status_reg = 8'h00;
  logic auto_accessory_level = 0, auto_plug_flip = 1;
  logic [1:0] auto_lane_select = 2'h2;
  wire pready, pslverr, power_alert, fault_alert, irq, rx_flush;
  wire accessory_indicator_out, accessory_indicator_oe, plug_flip_out, plug_flip_oe;
  wire lane_select0_out, lane_select0_oe, lane_select1_out, lane_select1_oe;
  wire watchdog_enable, side_output_owner, selftest_receive_mode;
  wire cable_power_on_cc1, monitor_on_cc2;
  wire [31:0] prdata;
  wire [3:0] pins = {accessory_indicator_out, lane_select1_out, lane_select0_out, plug_flip_out};
  wire [3:0] oes = {accessory_indicator_oe, lane_select1_oe, lane_select0_oe, plug_flip_oe};
  logic [31:0] rdv;
  logic errv;
  int fails = 0, check_count = 0, cycles = 0;

  pcr_regs DUT (.*);

  always #5 pclk = ~pclk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard: the directed run needs well under this many cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk(32'h0, 32'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    chk(rdv, {24'h000000, e});
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    // Reset values; pins follow the device sources while it owns them
    rd(12'h050, 8'hFF);
    rd(12'h054, 8'hB3);
    rd(12'h060, 8'h40);
    rd(12'h064, 8'h00);
    chk({28'h0, pins}, 32'h5);
    chk({28'h0, oes}, 32'hF);
    note("reset");
    // Read-write and read-only bits, strobe-less write ignored
    wr(12'h050, 8'hA5);
    pstrb <= 4'h0;
    wr(12'h050, 8'h00);
    pstrb <= 4'hF;
    rd(12'h050, 8'hA5);
    wr(12'h054, 8'hFF);
    rd(12'h054, 8'hB3);
    wr(12'h054, 8'h00);
    rd(12'h054, 8'h00);
    wr(12'h060, 8'h00);
    rd(12'h060, 8'h40);
    wr(12'h064, 8'hFF);
    rd(12'h064, 8'h33);
    chk({28'h0, watchdog_enable, side_output_owner, selftest_receive_mode,
      cable_power_on_cc1}, 32'hF);
    chk({31'h0, monitor_on_cc2}, 32'h1);
    note("access");
    // Host ownership: every lane code, indicator and flip level
    for (int i = 0; i < 4; i++) begin
      wr(12'h060, {1'b0, i[1], 2'b00, i[1:0], 1'b0, i[0]});
      repeat (2) @(posedge pclk);
      chk({28'h0, pins}, {28'h0, i[1], i[1], i[0], i[0]});
    end
    rd(12'h060, 8'h4D);
    wr(12'h060, 8'hFF);
    rd(12'h060, 8'hCD);
    repeat (2) @(posedge pclk);
    chk({28'h0, oes}, 32'h0);
    wr(12'h060, 8'h00);
    repeat (2) @(posedge pclk);
    chk({24'h0, oes, pins}, 32'hF0);
    note("outputs");
    // Self-test receive flush follows the acknowledgement by one edge
    goodcrc_sent <= 1;
    @(posedge pclk);
    goodcrc_sent <= 0;
    #1;
    chk({31'h0, rx_flush}, 32'h1);
    @(posedge pclk);
    hard_reset_rx <= 1;
    @(posedge pclk);
    hard_reset_rx <= 0;
    @(posedge pclk);
    rd(12'h050, 8'hFF);
    rd(12'h054, 8'hB3);
    rd(12'h064, 8'h33);
    note("hard reset");
    // Interrupt: hard reset event pending, then masked alerts
    chk({31'h0, irq}, 32'h0);
    wr(12'h084, 8'h07);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(12'h050, 8'h02);
    power_status_reg <= 8'h01;
    repeat (3) @(posedge pclk);
    chk({31'h0, power_alert}, 32'h0);
    rd(12'h080, 8'h04);
    power_status_reg <= 8'h03;
    repeat (3) @(posedge pclk);
    chk({31'h0, power_alert}, 32'h1);
    rd(12'h080, 8'h05);
    wr(12'h080, 8'h05);
    rd(12'h080, 8'h00);
    chk({31'h0, irq}, 32'h0);
    fault_status_reg <= 8'h04;
    repeat (3) @(posedge pclk);
    chk({31'h0, fault_alert}, 32'h0);
    fault_status_reg <= 8'h01;
    repeat (3) @(posedge pclk);
    chk({30'h0, fault_alert, irq}, 32'h3);
    rd(12'h080, 8'h02);
    wr(12'h084, 8'h00);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    note("interrupt");
    // Unmapped address answers with an error and zero data
    apb(12'h070, 1'b0, 8'h00);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
    wr(12'h054, 8'h00);
    software_reset <= 1;
    @(posedge pclk);
    software_reset <= 0;
    @(posedge pclk);
    rd(12'h064, 8'h00);
    rd(12'h060, 8'h40);
    rd(12'h050, 8'hFF);
    rd(12'h054, 8'hB3);
    chk({30'h0, cable_power_on_cc1, monitor_on_cc2}, 32'h0);
    // Outside self-test an acknowledgement must not flush
    goodcrc_sent <= 1;
    @(posedge pclk);
    goodcrc_sent <= 0;
    #1;
    chk({31'h0, rx_flush}, 32'h0);
    note("software reset");
    summarize();
  end
endmodule
